// ---- verilog/txss_consts.vh ----
`ifndef TXSS_CONSTS_VH
`define TXSS_CONSTS_VH
// ---------------------------------------------------------------
// address limits and reset value
// ---------------------------------------------------------------
`define TXSS_ADDR_MIN 6'h01
`define TXSS_ADDR_MAX 6'h3c
`define TXSS_ADDR_RST 6'h01
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define TXSS_CLK_HZ 10000000
`define TXSS_SLOT_US 25000
`define TXSS_SLOT_CYC ((`TXSS_CLK_HZ / 1000000) * `TXSS_SLOT_US)
// ---------------------------------------------------------------
// reset value of the accept-sync setting
// ---------------------------------------------------------------
`define TXSS_ACCEPT_RST 1'b1
`endif

// ---- verilog/txss_sync2.v ----
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// two-stage synchroniser
// ---------------------------------------------------------------
module txss_sync2 (
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    input wire d_i,
    output wire q_o
);
    reg s1_r;
    reg s2_r;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else if (ce_i) begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end
    assign q_o = s2_r;
endmodule // txss_sync2
`default_nettype wire

// ---- verilog/txss_gate.v ----
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// per-side transmitter gate
// ---------------------------------------------------------------
module txss_gate (
    input wire full_duty_i,
    input wire second_slot_i,
    input wire slot_i,
    output wire tx_on_o
);
    // full duty forces both slots on; half duty picks one slot
    assign tx_on_o = full_duty_i | (slot_i == second_slot_i);
endmodule // txss_gate
`default_nettype wire

// ---- verilog/txss_top.v ----
`timescale 1ns/1ns
`default_nettype none
`include "txss_consts.vh"
// Functional notes
// - only addresses 1 to 60 are accepted when a new address is written.
// - the address comes up as 1 after reset.
// - an address write is taken only from the direct USB path.
// - a USB session may open only while the enclosure tamper input is active.
// - every processor sends its own sync pulse at each cycle start.
// - a follower restarts its cycle on an incoming sync and then forwards it.
// - a master ignores incoming sync and runs on its own timing.
// - accept-sync low means master, high means follower; it resets high.
// - full duty keeps that side's transmitter on.
// - half duty gives 25 ms on then 25 ms off, repeating.
// - sides A and B have separate duty settings gating their own output.
// - in half duty a per-side coding bit picks the first or second slot.
// - in full duty both slots are on regardless of coding.
module txss_top #(
    parameter integer SLOT_CYC = `TXSS_SLOT_CYC
) (
    input wire REF_CLK_I,
    input wire RST_N_I,
    input wire CE_I,
    input wire TAMPER_ACTIVE_I,
    input wire USB_REQ_I,
    input wire ADDR_WR_I,
    input wire ADDR_VIA_USB_I,
    input wire [5:0] ADDR_NEW_I,
    input wire ACCEPT_SYNC_WR_I,
    input wire ACCEPT_SYNC_I,
    input wire DUTY_FULL_A_I,
    input wire DUTY_FULL_B_I,
    input wire SLOT2_A_I,
    input wire SLOT2_B_I,
    input wire SYNC_IN_I,
    output reg SYNC_OUT_O,
    output reg TX_ON_A_O,
    output reg TX_ON_B_O,
    output reg USB_SESSION_O,
    output reg [5:0] ADDR_O,
    output reg ADDR_REJECT_O,
    output reg SYNC_MASTER_O,
    output reg SLOT_O
);
    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    wire sync_in_s;
    wire tamper_s;
    reg sync_in_d_r;
    txss_sync2 u_sync_in (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i(SYNC_IN_I),
        .q_o(sync_in_s)
    );
    txss_sync2 u_tamper (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .d_i(TAMPER_ACTIVE_I),
        .q_o(tamper_s)
    );
    // ---------------------------------------------------------------
    // configuration
    // ---------------------------------------------------------------
    reg accept_r;
    wire addr_ok;
    assign addr_ok = (ADDR_NEW_I >= `TXSS_ADDR_MIN) &&
                     (ADDR_NEW_I <= `TXSS_ADDR_MAX);
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ADDR_O <= `TXSS_ADDR_RST;
            ADDR_REJECT_O <= 1'b0;
            accept_r <= `TXSS_ACCEPT_RST;
            USB_SESSION_O <= 1'b0;
        end else if (CE_I) begin
            // session drops three enabled clocks after the door closes (two synchroniser stages, then this register)
            USB_SESSION_O <= USB_REQ_I & tamper_s;
            ADDR_REJECT_O <= 1'b0;
            if (ADDR_WR_I) begin
                if (ADDR_VIA_USB_I && USB_SESSION_O && addr_ok) begin
                    ADDR_O <= ADDR_NEW_I;
                end else begin
                    ADDR_REJECT_O <= 1'b1;
                end
            end
            if (ACCEPT_SYNC_WR_I) begin
                accept_r <= ACCEPT_SYNC_I;
            end
        end
    end
    // ---------------------------------------------------------------
    // slot timing
    // ---------------------------------------------------------------
    reg [31:0] cnt_r;
    reg slot_r;
    wire sync_rise;
    wire resync;
    assign sync_rise = sync_in_s & ~sync_in_d_r;
    // a master never restarts from outside, so two masters cannot fight
    assign resync = sync_rise & accept_r;
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync_in_d_r <= 1'b0;
            cnt_r <= 32'h0;
            slot_r <= 1'b0;
            SYNC_OUT_O <= 1'b0;
        end else if (CE_I) begin
            sync_in_d_r <= sync_in_s;
            SYNC_OUT_O <= 1'b0;
            if (resync) begin
                cnt_r <= 32'h0;
                slot_r <= 1'b0;
                SYNC_OUT_O <= 1'b1;
            end else if (cnt_r == SLOT_CYC - 1) begin
                cnt_r <= 32'h0;
                slot_r <= ~slot_r;
                // each cycle start emits our own sync onward
                SYNC_OUT_O <= slot_r;
            end else begin
                cnt_r <= cnt_r + 32'h1;
            end
        end
    end
    // ---------------------------------------------------------------
    // transmitter gates
    // ---------------------------------------------------------------
    wire slot_next;
    wire tx_a;
    wire tx_b;
    assign slot_next = resync ? 1'b0 :
                       (cnt_r == SLOT_CYC - 1) ? ~slot_r : slot_r;
    txss_gate u_gate_a (
        .full_duty_i(DUTY_FULL_A_I),
        .second_slot_i(SLOT2_A_I),
        .slot_i(slot_next),
        .tx_on_o(tx_a)
    );
    txss_gate u_gate_b (
        .full_duty_i(DUTY_FULL_B_I),
        .second_slot_i(SLOT2_B_I),
        .slot_i(slot_next),
        .tx_on_o(tx_b)
    );
    always @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            TX_ON_A_O <= 1'b0;
            TX_ON_B_O <= 1'b0;
            SYNC_MASTER_O <= 1'b0;
            SLOT_O <= 1'b0;
        end else if (CE_I) begin
            TX_ON_A_O <= tx_a;
            TX_ON_B_O <= tx_b;
            SYNC_MASTER_O <= ~accept_r;
            SLOT_O <= slot_next;
        end
    end
endmodule // txss_top
`default_nettype wire

// ---- dv/txss_peer.sv ----
`timescale 1ns/1ns
`default_nettype none
module txss_peer (
    input wire logic clk_i,
    input wire logic fire_i,
    output wire logic sync_o
);
    logic [1:0] hold_r = 2'h0;
    // two cycles high, so the receiver sees one clean rising edge
    always @(posedge clk_i) begin
        hold_r <= fire_i ? 2'h3 : {hold_r[0], 1'b0};
    end
    assign sync_o = hold_r[1];
endmodule // txss_peer
`default_nettype wire

// ---- dv/txss_top_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module txss_top_properties #(
    parameter integer SLOT_CYC = 8
) (
    input wire logic REF_CLK_I, RST_N_I, TAMPER_ACTIVE_I, ADDR_WR_I,
    input wire logic ADDR_VIA_USB_I, DUTY_FULL_A_I, DUTY_FULL_B_I,
    input wire logic SLOT2_B_I, SYNC_IN_I, SYNC_OUT_O, TX_ON_A_O,
    input wire logic TX_ON_B_O, USB_SESSION_O, ADDR_REJECT_O,
    input wire logic SYNC_MASTER_O, SLOT_O, CE_I,
    input wire logic [5:0] ADDR_NEW_I, ADDR_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    int cnt_r = 0;
    logic seen_r = 1'b0;
    // slot age is trusted only after a first cycle start
    always @(posedge REF_CLK_I) begin
        // slot age holds while the enable freezes the design
        cnt_r <= (!RST_N_I || $changed(SLOT_O) || SYNC_OUT_O) ? 0 :
                 cnt_r + (CE_I ? 1 : 0);
        seen_r <= RST_N_I && (seen_r || SYNC_OUT_O);
    end
    sequence s_bad_wr;
        ADDR_WR_I && (ADDR_NEW_I == 6'h00 || ADDR_NEW_I > 6'h3c);
    endsequence
    sequence s_fol_edge;
        $rose(SYNC_IN_I) && !SYNC_MASTER_O;
    endsequence
    a_bad_reject: assert property (
        s_bad_wr |=> ADDR_REJECT_O && $stable(ADDR_O)) else $error("bad addr");
    a_usb_only: assert property (
        ADDR_WR_I && !ADDR_VIA_USB_I |=> $stable(ADDR_O)) else $error("path");
    a_tamper_gate: assert property (
        !TAMPER_ACTIVE_I [*4] |-> !USB_SESSION_O) else $error("session");
    a_full_on: assert property (
        DUTY_FULL_A_I |=> TX_ON_A_O) else $error("full duty");
    a_half_slot: assert property (
        !DUTY_FULL_B_I |=> TX_ON_B_O == (SLOT_O == $past(SLOT2_B_I)))
        else $error("half duty");
    a_follow_fwd: assert property (
        s_fol_edge |-> ##[2:5] SYNC_OUT_O) else $error("no forward");
    a_master_wrap: assert property (
        SYNC_OUT_O && SYNC_MASTER_O && seen_r |-> cnt_r == SLOT_CYC - 1
        && $past(SLOT_O)) else $error("master restart");
    a_slot_len: assert property (
        $rose(SLOT_O) && seen_r |-> cnt_r == SLOT_CYC - 1) else $error("slot");
endmodule // txss_top_properties
bind txss_top txss_top_properties #(.SLOT_CYC(SLOT_CYC)) i_props (.*);
`default_nettype wire

// ---- dv/txss_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module txss_top_tb;
    logic REF_CLK_I = 1'b0, RST_N_I = 1'b0, CE_I = 1'b1, fire = 1'b0;
    logic TAMPER_ACTIVE_I, USB_REQ_I, ADDR_WR_I, ADDR_VIA_USB_I, SLOT2_A_I;
    logic ACCEPT_SYNC_WR_I, ACCEPT_SYNC_I, DUTY_FULL_A_I, DUTY_FULL_B_I;
    logic SLOT2_B_I;
    logic [5:0] ADDR_NEW_I;
    wire logic SYNC_IN_I, SYNC_OUT_O, TX_ON_A_O, TX_ON_B_O, USB_SESSION_O;
    wire logic ADDR_REJECT_O, SYNC_MASTER_O, SLOT_O;
    wire logic [5:0] ADDR_O;
    int n_mismatch = 0, check_count = 0;
    txss_top #(.SLOT_CYC(8)) i_txss_top (.*);
    txss_peer i_txss_peer (.clk_i(REF_CLK_I), .fire_i(fire),
        .sync_o(SYNC_IN_I));
    always #50 REF_CLK_I = ~REF_CLK_I;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask
    task wsync(input int lim);
        for (int k = 0; SYNC_OUT_O !== 1'b1; k++) begin
            if (k == lim) n_mismatch++;
            if (k == lim) conclude;
            cyc(1);
        end
    endtask
    task wr(input logic [5:0] a, input logic usb);
        @(posedge REF_CLK_I);
        ADDR_WR_I <= 1'b1;
        ADDR_NEW_I <= a;
        ADDR_VIA_USB_I <= usb;
        @(posedge REF_CLK_I);
        ADDR_WR_I <= 1'b0;
        #1;
    endtask
    task t_addr;
        chk({SYNC_MASTER_O, ADDR_O}, 8'h01);
        @(posedge REF_CLK_I);
        TAMPER_ACTIVE_I <= 1'b1;
        USB_REQ_I <= 1'b1;
        cyc(4);
        chk(USB_SESSION_O, 8'h01);
        wr(6'h3c, 1'b1);
        chk({ADDR_REJECT_O, ADDR_O}, 8'h3c);
        wr(6'h3d, 1'b1);
        chk({ADDR_REJECT_O, ADDR_O}, 8'h7c);
        wr(6'h00, 1'b1);
        chk({ADDR_REJECT_O, ADDR_O}, 8'h7c);
        wr(6'h07, 1'b0);
        chk(ADDR_O, 8'h3c);
        @(posedge REF_CLK_I);
        TAMPER_ACTIVE_I <= 1'b0;
        cyc(4);
        wr(6'h05, 1'b1);
        chk({USB_SESSION_O, ADDR_O}, 8'h3c);
    endtask
    task t_role(input logic acc);
        @(posedge REF_CLK_I);
        ACCEPT_SYNC_WR_I <= 1'b1;
        ACCEPT_SYNC_I <= acc;
        @(posedge REF_CLK_I);
        ACCEPT_SYNC_WR_I <= 1'b0;
        cyc(1);
        chk(SYNC_MASTER_O, {7'h00, ~acc});
    endtask
    task t_slots(input logic fa, input logic s2a);
        @(posedge REF_CLK_I);
        DUTY_FULL_A_I <= fa;
        SLOT2_A_I <= s2a;
        SLOT2_B_I <= 1'b1;
        cyc(1);
        wsync(40);
        for (int i = 0; i < 16; i++) begin
            chk({SLOT_O, TX_ON_A_O, TX_ON_B_O}, {i >= 8, fa | ((i >= 8) == s2a),
                i >= 8});
            cyc(1);
        end
        chk(SYNC_OUT_O, 8'h01);
    endtask
    task t_freeze;
        logic s;
        @(posedge REF_CLK_I);
        CE_I <= 1'b0;
        cyc(1);
        s = SLOT_O;
        repeat (12) begin
            cyc(1);
            chk({SYNC_OUT_O, SLOT_O}, {7'h00, s});
        end
        @(posedge REF_CLK_I);
        CE_I <= 1'b1;
        #1;
    endtask
    task t_fire;
        @(posedge REF_CLK_I);
        fire <= 1'b1;
        @(posedge REF_CLK_I);
        fire <= 1'b0;
        #1;
    endtask
    initial begin
        {TAMPER_ACTIVE_I, USB_REQ_I, ADDR_WR_I, ADDR_VIA_USB_I, SLOT2_A_I} = '0;
        {ACCEPT_SYNC_WR_I, ACCEPT_SYNC_I, DUTY_FULL_A_I, DUTY_FULL_B_I} = '0;
        {SLOT2_B_I, ADDR_NEW_I} = '0;
        repeat (16) @(posedge REF_CLK_I);
        RST_N_I <= 1'b1;
        cyc(1);
        t_addr;
        t_role(1'b0);
        t_slots(1'b1, 1'b0);
        t_slots(1'b0, 1'b0);
        t_slots(1'b0, 1'b1);
        t_fire;
        repeat (8) begin
            cyc(1);
            chk(SYNC_OUT_O, 8'h00);
        end
        t_role(1'b1);
        wsync(40);
        cyc(4);
        t_fire;
        wsync(8);
        chk(SLOT_O, 8'h00);
        t_freeze;
        conclude;
    end
endmodule // txss_top_tb
`default_nettype wire
